//--- core/ufc_pkg.sv
// Constants and types for the frame configuration block.
//
// How it works
// RQ1: parity_type decodes even, odd, space, mark, none, multidrop.
// RQ2: Async stop_bit_count 00/01/10 gives 1, 1.5, 2 stops; 11 reserved.
// RQ3: Sync stop_bit_count 00 gives 1, 10 gives 2; others reserved.
// RQ4: Automatic echo sends the receive line straight to the transmit pin.
// RQ5: Local loopback feeds the transmitter output to the receiver.
// RQ6: Remote loopback ties receive pin to transmit pin; 00 is normal.
// RQ7: msb_first selects most significant bit first, else least first.
// RQ8: nine_bit_char forces 9-bit characters, else char_length_sel rules.
// RQ9: Clock pin driven only with clock_out_drive and internal clock.
// RQ10: negative_ack_inhibit suppresses every negative acknowledge.
// RQ11: Without the limit, each parity error gives an immediate NEGATIVE_ACK.
// RQ12: With the limit, consecutive parity errors are counted, each NACKed.
// RQ13: At repeat_limit no more NACKs and the limit flag is set.
// RQ14: repeat_limit is the maximum repetition count for T=0.
// RQ15: With sync_field_from_tx_write, each holding write updates sync.
// RQ16: Otherwise the sync field follows the synchronous-mode setting.
// RQ17: Infrared filter takes 2-of-3 majority at 1/16 bit spacing.
// RQ18: biphase_codec_en enables both biphase encoder and decoder.
// RQ19: single_bit_delimiter 1 selects a one-bit start delimiter.
// RQ20: single_bit_delimiter 0 selects a command or data sync delimiter.
// RQ21: Writing 1 to interrupt_enable_set sets that mask bit.
// RQ22: Writing 1 to interrupt_enable_clear clears that mask bit.
// RQ23: Interrupt bits sit at their fixed positions 0-13 and 16-20.
// RQ24: interrupt_mask_view reads 1 for enabled sources.
// RQ25: Synchronous-mode bit 0 is async, 1 sync; picks stop-bit column.
// RQ26: Interrupt output is high when any enabled flag is active.
package ufc_pkg;

   localparam int AW = 8;

   localparam logic [AW-1:0] OFS_CTRL  = 8'h00;
   localparam logic [AW-1:0] OFS_MODE  = 8'h04;
   localparam logic [AW-1:0] OFS_IEN   = 8'h08;
   localparam logic [AW-1:0] OFS_IDIS  = 8'h0C;
   localparam logic [AW-1:0] OFS_IMASK = 8'h10;
   localparam logic [AW-1:0] OFS_STAT  = 8'h14;
   localparam logic [AW-1:0] OFS_TXH   = 8'h1C;

   localparam int CTL_CLR_REPEAT = 10;
   localparam int CTL_CLR_NEGATIVE_ACK   = 14;
   localparam int TXH_CMD_BIT    = 15;

   localparam int IRQ_REPEAT = 10;
   localparam int IRQ_NEGATIVE_ACK   = 13;
   localparam logic [31:0] IRQ_USED   = 32'h001F3FFF;
   localparam logic [31:0] MODE_WMASK = 32'hB77FFFFF;
   localparam logic [31:0] MODE_RESET = 32'h00000000;

   localparam logic [1:0] CLK_EXT_SCK = 2'h3;
   localparam int         FILT_TAPS   = 3;

   typedef enum logic [2:0] {
      PAR_EVEN, PAR_ODD, PAR_SPACE, PAR_MARK, PAR_NONE, PAR_MULTI
   } ufc_parity_t;

   typedef enum logic [1:0] {
      CH_NORMAL, CH_ECHO, CH_LOCAL, CH_REMOTE
   } ufc_chan_t;

   typedef struct packed {
      logic       single_bit_delimiter;
      logic       rsv30;
      logic       biphase_codec_en;
      logic       ir_filter;
      logic       rsv27;
      logic [2:0] repeat_limit;
      logic       rsv23;
      logic       sync_field_from_tx_write;
      logic       successive_negative_ack_limit_en;
      logic       negative_ack_inhibit;
      logic       oversample8;
      logic       clock_out_drive;
      logic       nine_bit_char;
      logic       msb_first;
      logic [1:0] channel_mode;
      logic [1:0] stop_bit_count;
      logic [2:0] parity_type;
      logic       sync_mode;
      logic [1:0] char_length_sel;
      logic [1:0] clock_source_sel;
      logic [3:0] usart_mode;
   } ufc_mode_t;

   typedef struct packed {
      ufc_parity_t parity;
      logic [2:0]  stop_halves;
      logic        stop_rsvd;
      logic [3:0]  char_bits;
      logic        msb_first;
      logic        biphase_en;
      logic        sfd_one_bit;
      logic        sfd_cmd_sync;
      logic [2:0]  repeat_limit;
   } ufc_frame_t;

endpackage : ufc_pkg

//--- core/ufc_core.sv
// Frame configuration, channel routing, NEGATIVE_ACK control and interrupt mask.
`timescale 1ns/1ps
module ufc_core
   import ufc_pkg::*;
#(
   parameter int CW = 9
) (
   // Clock and reset.
   input  wire logic          clk_i,
   input  wire logic          rst_b_i,
   // Register port.
   input  wire logic [AW-1:0] reg_addr_i,
   input  wire logic [31:0]   reg_wdata_i,
   input  wire logic          reg_wr_i,
   input  wire logic          reg_rd_i,
   output logic [31:0]        reg_rdata_o,
   // Status levels from the rest of the channel.
   input  wire logic [31:0]   evt_flags_i,
   output logic               irq_o,
   // Receiver character events.
   input  wire logic          rx_char_done_i,
   input  wire logic          rx_par_err_i,
   input  wire logic [CW-1:0] rx_data_i,
   output logic [CW-1:0]      rx_data_o,
   output logic               negative_ack_o,
   // Transmit holding path.
   output logic               tx_wr_o,
   output logic [CW-1:0]      tx_data_o,
   // Serial lines.
   input  wire logic          rx_pin_i,
   input  wire logic          os_tick_i,
   input  wire logic          tx_ser_i,
   output logic               tx_pin_o,
   output logic               rx_ser_o,
   // Serial clock pin.
   input  wire logic          sck_gen_i,
   output logic               sck_o,
   output logic               sck_oe_b_o,
   // Decoded frame settings.
   output ufc_frame_t         cfg_o
);

   ////////////////////////////////////////////////////////////////////
   // Helpers.

   function automatic logic [3:0] char_len(input ufc_mode_t m);
      logic [3:0] n;
      n = 4'h5 + {2'h0, m.char_length_sel};
      if (m.nine_bit_char) begin
         n = 4'h9; // [RQ8]
      end
      return n;
   endfunction : char_len

   // With msb set, mirrors the low n bits so the shifter always sends bit 0 first.
   function automatic logic [CW-1:0] order_bits(
      input logic [CW-1:0] d,
      input logic [3:0]    n,
      input logic          msb
   );
      logic [CW-1:0] r;
      r = d;
      if (msb) begin
         r = '0;
         for (int i = 0; i < CW; i++) begin
            if (i < int'(n)) begin
               r[i] = d[int'(n) - 1 - i]; // [RQ7]
            end
         end
      end
      return r;
   endfunction : order_bits

   // Keeps only the bit positions that carry an interrupt source.
   function automatic logic [31:0] irq_bits(input logic [31:0] v);
      return v & IRQ_USED;
   endfunction : irq_bits

   // True when a write strobe addresses the given offset.
   function automatic logic wr_hit(
      input logic          we,
      input logic [AW-1:0] a,
      input logic [AW-1:0] ofs
   );
      return we && (a == ofs);
   endfunction : wr_hit

   ////////////////////////////////////////////////////////////////////
   // Register decode.

   ufc_mode_t   mode_q;
   logic [31:0] imask_q;
   logic [31:0] rdata_q;

   wire wr_ctrl  = wr_hit(reg_wr_i, reg_addr_i, OFS_CTRL);
   wire wr_mode  = wr_hit(reg_wr_i, reg_addr_i, OFS_MODE);
   wire wr_ien   = wr_hit(reg_wr_i, reg_addr_i, OFS_IEN);
   wire wr_idis  = wr_hit(reg_wr_i, reg_addr_i, OFS_IDIS);
   wire wr_txh   = wr_hit(reg_wr_i, reg_addr_i, OFS_TXH);
   wire clr_rep  = wr_ctrl && reg_wdata_i[CTL_CLR_REPEAT];
   wire clr_negative_ack = wr_ctrl && reg_wdata_i[CTL_CLR_NEGATIVE_ACK];

   // Reserved bits are dropped on write so they always read back as zero.
   wire ufc_mode_t mode_d = ufc_mode_t'(reg_wdata_i & MODE_WMASK);

   wire [31:0] ien_bits  = irq_bits(reg_wdata_i);
   wire [31:0] idis_bits = irq_bits(reg_wdata_i);
   wire [31:0] imask_d   = wr_ien  ? (imask_q | ien_bits)   // [RQ21]
                         : wr_idis ? (imask_q & ~idis_bits) // [RQ22]
                         : imask_q;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mode_q  <= ufc_mode_t'(MODE_RESET);
         imask_q <= '0;
      end else begin
         imask_q <= imask_d;
         if (wr_mode) begin
            mode_q <= mode_d;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Status and interrupt.

   logic repeat_flag_q;
   logic negative_ack_flag_q;
   logic [31:0] status;

   // Limit and NEGATIVE_ACK flags are owned here; the rest come from outside.
   always_comb begin
      status             = irq_bits(evt_flags_i); // [RQ23]
      status[IRQ_REPEAT] = repeat_flag_q;
      status[IRQ_NEGATIVE_ACK]   = negative_ack_flag_q;
   end

   wire irq_any = |(status & imask_q); // [RQ26]

   // Unmapped and write-only offsets read as zero.
   wire [31:0] rd_mux =
        (reg_addr_i == OFS_MODE)  ? 32'(mode_q)
      : (reg_addr_i == OFS_IMASK) ? imask_q // [RQ24]
      : (reg_addr_i == OFS_STAT)  ? status
      : 32'h00000000;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_q <= '0;
         irq_o   <= 1'b0;
      end else begin
         rdata_q <= reg_rd_i ? rd_mux : 32'h00000000;
         irq_o   <= irq_any;
      end
   end

   assign reg_rdata_o = rdata_q;

   ////////////////////////////////////////////////////////////////////
   // Frame settings.

   ufc_parity_t par_dec;
   logic [2:0]  stop_halves;
   logic        stop_rsvd;
   ufc_frame_t  cfg_q;

   always_comb begin
      case (mode_q.parity_type) // [RQ1]
         3'h0:    par_dec = PAR_EVEN;
         3'h1:    par_dec = PAR_ODD;
         3'h2:    par_dec = PAR_SPACE;
         3'h3:    par_dec = PAR_MARK;
         3'h4,
         3'h5:    par_dec = PAR_NONE;
         default: par_dec = PAR_MULTI;
      endcase
   end

   // Stop length in half bits; the sync bit picks the column.
   always_comb begin
      stop_rsvd = 1'b0;
      case (mode_q.stop_bit_count)
         2'h0: begin
            stop_halves = 3'h2; // [RQ2] [RQ3]
         end
         2'h1: begin
            stop_halves = 3'h3; // [RQ2]
            stop_rsvd   = mode_q.sync_mode; // [RQ3] [RQ25]
         end
         2'h2: begin
            stop_halves = 3'h4; // [RQ2] [RQ3]
         end
         default: begin
            stop_halves = 3'h2;
            stop_rsvd   = 1'b1;
         end
      endcase
   end

   logic txh_cmd_q;

   // Sync field: from the last holding write, or from the sync bit.
   wire sfd_cmd = mode_q.sync_field_from_tx_write
                ? txh_cmd_q // [RQ15]
                : mode_q.sync_mode; // [RQ16]

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         txh_cmd_q <= 1'b0;
         cfg_q     <= '0;
      end else begin
         if (wr_txh && mode_q.sync_field_from_tx_write) begin
            txh_cmd_q <= reg_wdata_i[TXH_CMD_BIT]; // [RQ15]
         end
         cfg_q.parity       <= par_dec;
         cfg_q.stop_halves  <= stop_halves;
         cfg_q.stop_rsvd    <= stop_rsvd;
         cfg_q.char_bits    <= char_len(mode_q); // [RQ8]
         cfg_q.msb_first    <= mode_q.msb_first;
         cfg_q.biphase_en   <= mode_q.biphase_codec_en; // [RQ18]
         cfg_q.sfd_one_bit  <= mode_q.single_bit_delimiter; // [RQ19]
         cfg_q.sfd_cmd_sync <= sfd_cmd; // [RQ20]
         cfg_q.repeat_limit <= mode_q.repeat_limit; // [RQ14]
      end
   end

   assign cfg_o = cfg_q;

   ////////////////////////////////////////////////////////////////////
   // Character bit order.

   wire [3:0] nbits = char_len(mode_q);

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tx_wr_o   <= 1'b0;
         tx_data_o <= '0;
         rx_data_o <= '0;
      end else begin
         tx_wr_o <= wr_txh;
         if (wr_txh) begin
            tx_data_o <= order_bits(reg_wdata_i[CW-1:0], nbits,
                                    mode_q.msb_first); // [RQ7]
         end
         if (rx_char_done_i) begin
            rx_data_o <= order_bits(rx_data_i, nbits,
                                    mode_q.msb_first); // [RQ7]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Receive line: synchroniser and infrared filter.

   logic rx_meta_q;
   logic rx_sync_q;
   logic [FILT_TAPS-1:0] taps_q;

   // The pin is not on this clock, so two stages come before any use.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rx_meta_q <= 1'b1;
         rx_sync_q <= 1'b1;
         taps_q    <= '1;
      end else begin
         rx_meta_q <= rx_pin_i;
         rx_sync_q <= rx_meta_q;
         if (os_tick_i) begin
            taps_q <= {taps_q[FILT_TAPS-2:0], rx_sync_q}; // [RQ17]
         end
      end
   end

   wire rx_vote = (taps_q[0] & taps_q[1]) | (taps_q[1] & taps_q[2])
                | (taps_q[0] & taps_q[2]); // [RQ17]
   wire rx_line = mode_q.ir_filter ? rx_vote : rx_sync_q; // [RQ17]

   ////////////////////////////////////////////////////////////////////
   // Channel routing.

   logic tx_pin_d;
   logic rx_ser_d;

   // Remote loopback takes the pin unfiltered so each bit is resent as seen.
   always_comb begin
      case (ufc_chan_t'(mode_q.channel_mode))
         CH_NORMAL: begin
            tx_pin_d = tx_ser_i;
            rx_ser_d = rx_line;
         end
         CH_ECHO: begin
            tx_pin_d = rx_line; // [RQ4]
            rx_ser_d = rx_line; // [RQ4]
         end
         CH_LOCAL: begin
            tx_pin_d = 1'b1;
            rx_ser_d = tx_ser_i; // [RQ5]
         end
         CH_REMOTE: begin
            tx_pin_d = rx_sync_q; // [RQ6]
            rx_ser_d = 1'b1;
         end
         default: begin
            tx_pin_d = 1'b1;
            rx_ser_d = 1'b1;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // Serial clock pin.

   wire sck_drive = mode_q.clock_out_drive
                 && (mode_q.clock_source_sel != CLK_EXT_SCK); // [RQ9]

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tx_pin_o   <= 1'b1;
         rx_ser_o   <= 1'b1;
         sck_o      <= 1'b0;
         sck_oe_b_o <= 1'b1;
      end else begin
         tx_pin_o   <= tx_pin_d;
         rx_ser_o   <= rx_ser_d;
         sck_o      <= sck_drive & sck_gen_i;
         sck_oe_b_o <= ~sck_drive; // [RQ9]
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Negative acknowledge and repetition limit.

   // The count stops at the limit; it can only wrap back to zero if repeat_limit is lowered below it.
   logic [2:0] err_cnt_q;

   wire par_evt   = rx_char_done_i && rx_par_err_i;
   wire good_evt  = rx_char_done_i && !rx_par_err_i;
   wire at_limit  = (err_cnt_q == mode_q.repeat_limit); // [RQ13]
   wire lim_on    = mode_q.successive_negative_ack_limit_en;
   wire want_negative_ack = par_evt && !(lim_on && at_limit); // [RQ11] [RQ13]
   wire send_negative_ack = want_negative_ack && !mode_q.negative_ack_inhibit; // [RQ10]
   wire cnt_step  = par_evt && lim_on && !at_limit; // [RQ12]
   wire [2:0] cnt_next = err_cnt_q + 3'h1;
   wire hit_limit = lim_on && par_evt
                 && (at_limit || cnt_next == mode_q.repeat_limit);

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         err_cnt_q     <= '0;
         negative_ack_o        <= 1'b0;
         repeat_flag_q <= 1'b0;
         negative_ack_flag_q   <= 1'b0;
      end else begin
         negative_ack_o <= send_negative_ack; // [RQ10] [RQ11]
         if (good_evt || clr_rep) begin
            err_cnt_q <= '0;
         end else if (cnt_step) begin
            err_cnt_q <= cnt_next; // [RQ12]
         end
         // A new event wins over a clear in the same cycle.
         if (hit_limit) begin
            repeat_flag_q <= 1'b1; // [RQ13]
         end else if (clr_rep) begin
            repeat_flag_q <= 1'b0;
         end
         if (send_negative_ack) begin
            negative_ack_flag_q <= 1'b1;
         end else if (clr_negative_ack) begin
            negative_ack_flag_q <= 1'b0;
         end
      end
   end

endmodule : ufc_core

//--- verif/ufc_checker.sv
// Concurrent checks on the ports of the frame configuration block.
`timescale 1ns/1ps
module ufc_checker
   import ufc_pkg::*;
#(
   parameter int CW = 9
) (
   // Clock and reset.
   input wire logic          clk_i,
   input wire logic          rst_b_i,
   // Register port.
   input wire logic [AW-1:0] reg_addr_i,
   input wire logic [31:0]   reg_wdata_i,
   input wire logic          reg_wr_i,
   input wire logic          reg_rd_i,
   input wire logic [31:0]   reg_rdata_o,
   // Status and interrupt.
   input wire logic [31:0]   evt_flags_i,
   input wire logic          irq_o,
   // Receive and transmit character paths.
   input wire logic          rx_char_done_i,
   input wire logic          rx_par_err_i,
   input wire logic [CW-1:0] rx_data_i,
   input wire logic [CW-1:0] rx_data_o,
   input wire logic          negative_ack_o,
   input wire logic          tx_wr_o,
   // Clock pin and decoded settings.
   input wire logic          sck_o,
   input wire logic          sck_oe_b_o,
   input wire ufc_frame_t    cfg_o
);
   // External levels at the limit and NEGATIVE_ACK positions never reach status.
   localparam logic [31:0] EVT_M = IRQ_USED & 32'hFFFFDBFF;
   wire rd_mask = reg_rd_i && reg_addr_i == OFS_IMASK;
   default clocking dc @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   a_rdata_idle: assert property (
      !$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
      else $error("read data present without a read");
   a_enable_set: assert property (
      (reg_wr_i && reg_addr_i == OFS_IEN) ##1 rd_mask |=>
      (reg_rdata_o & $past(reg_wdata_i, 2) & IRQ_USED)
      == ($past(reg_wdata_i, 2) & IRQ_USED))
      else $error("enabled bits missing from mask view");
   a_enable_clear: assert property (
      (reg_wr_i && reg_addr_i == OFS_IDIS) ##1 rd_mask |=>
      (reg_rdata_o & $past(reg_wdata_i, 2) & IRQ_USED) == 32'h0)
      else $error("disabled bits still in mask view");
   a_irq_masked: assert property (
      rd_mask |=> (reg_rdata_o == 32'h0) -> !irq_o)
      else $error("interrupt raised with empty mask");
   a_irq_raised: assert property (
      rd_mask |=> ((reg_rdata_o & $past(evt_flags_i) & EVT_M) != 32'h0)
      -> irq_o)
      else $error("enabled active flag gave no interrupt");
   a_negative_ack_cause: assert property (
      negative_ack_o |-> $past(rx_char_done_i && rx_par_err_i))
      else $error("negative acknowledge without parity error");
   a_good_char: assert property (
      rx_char_done_i && !rx_par_err_i |=> !negative_ack_o)
      else $error("negative acknowledge after a good character");
   a_tx_pulse: assert property (
      tx_wr_o == $past(reg_wr_i && reg_addr_i == OFS_TXH))
      else $error("holding write pulse mistimed");
   a_sck_idle: assert property (
      sck_oe_b_o |-> !sck_o)
      else $error("clock pin active while released");
   a_lsb_order: assert property (
      rx_char_done_i && !cfg_o.msb_first && cfg_o.char_bits == 4'h9
      |=> rx_data_o == $past(rx_data_i))
      else $error("received character reordered in lsb mode");
endmodule : ufc_checker

//--- verif/ufc_remote.sv
// Remote serial partner that drives the receive line of the block.
`timescale 1ns/1ps
module ufc_remote (
   // Line control from the bench.
   input  wire logic send_i,
   input  wire logic bit_i,
   // Lines toward and from the block.
   input  wire logic tx_line_i,
   output logic      rx_line_o,
   output logic      tx_seen_o
);
   // An idle partner drives the line high itself, so it sits at mark.
   assign rx_line_o = send_i ? bit_i : 1'b1;
   assign tx_seen_o = tx_line_i;
endmodule : ufc_remote

//--- verif/tb_usart_frame_config_irq_enable.sv
// Directed bench for the frame configuration block.
`timescale 1ns/1ps
module tb_usart_frame_config_irq_enable
   import ufc_pkg::*;
;
   localparam int CW = 9;
   logic          clk_i          = 1'b0;
   logic          rst_b_i        = 1'b0;
   logic [AW-1:0] reg_addr_i     = 8'h00;
   logic [31:0]   reg_wdata_i    = 32'h0;
   logic          reg_wr_i       = 1'b0;
   logic          reg_rd_i       = 1'b0;
   logic [31:0]   evt_flags_i    = 32'h0;
   logic          rx_char_done_i = 1'b0;
   logic          rx_par_err_i   = 1'b0;
   logic [CW-1:0] rx_data_i      = 9'h15A;
   logic          os_tick_i      = 1'b0;
   logic          tx_ser_i       = 1'b1;
   logic          sck_gen_i      = 1'b1;
   logic          send           = 1'b0;
   logic          line_bit       = 1'b0;
   logic [31:0]   reg_rdata_o;
   logic [CW-1:0] rx_data_o;
   logic [CW-1:0] tx_data_o;
   logic          irq_o;
   logic          negative_ack_o;
   logic          tx_wr_o;
   logic          rx_pin_i;
   logic          tx_pin_o;
   logic          rx_ser_o;
   logic          sck_o;
   logic          sck_oe_b_o;
   logic          tx_seen;
   ufc_frame_t    cfg_o;
   ufc_mode_t     m;
   logic [2:0]    k;
   logic [1:0]    sb;
   logic          rsv;
   int            miscompares     = 0;
   int            samples_checked = 0;

   ufc_core #(.CW(CW)) dut (.*);
   ufc_remote u_remote (.send_i(send), .bit_i(line_bit),
      .tx_line_i(tx_pin_o), .rx_line_o(rx_pin_i), .tx_seen_o(tx_seen));

   initial forever #2.5 clk_i = ~clk_i;

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h wanted %h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : cyc
   task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge clk_i);
      reg_wr_i    <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [AW-1:0] a, input logic [31:0] e);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge clk_i);
      reg_rd_i   <= 1'b0;
      #1;
      chk(reg_rdata_o, e);
   endtask : rd
   task automatic setm();
      wr(OFS_MODE, m);
      cyc(2);
   endtask : setm
   task automatic tick();
      os_tick_i <= 1'b1;
      cyc(1);
      os_tick_i <= 1'b0;
      cyc(1);
   endtask : tick
   task automatic chr(input logic err, input logic exp_negative_ack);
      rx_char_done_i <= 1'b1;
      rx_par_err_i   <= err;
      cyc(1);
      rx_char_done_i <= 1'b0;
      chk(negative_ack_o, exp_negative_ack);
      cyc(1);
   endtask : chr
   task automatic test_done();
      $display("compared %0d mismatched %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : test_done

   ////////////////////////////////////////////////////////////////////////
   initial begin
      #200000;
      miscompares++;
      test_done();
   end

   initial begin
      cyc(2);
      rst_b_i <= 1'b1;
      cyc(1);
      chk({tx_pin_o, sck_oe_b_o}, 2'b11);
      rd(OFS_IMASK, 32'h0);
      wr(OFS_MODE, 32'hFFFFFFFF);
      rd(OFS_MODE, MODE_WMASK);
      rd(8'hFC, 32'h0);
      for (int i = 0; i < 8; i++) begin
         k = 3'(i);
         sb = k[1:0];
         m = '0;
         m.parity_type = k;
         m.stop_bit_count = sb;
         m.sync_mode = k[2];
         m.char_length_sel = sb;
         m.nine_bit_char = (k == 3'h7);
         m.biphase_codec_en = k[0];
         m.single_bit_delimiter = k[1];
         m.repeat_limit = k;
         m.msb_first = k[0];
         setm();
         chk(cfg_o.parity, k < 4 ? 32'(k) : k < 6 ? 4 : 5);
         rsv = (sb == 2'h3) || (k[2] && sb == 2'h1);
         chk(cfg_o.stop_rsvd, rsv);
         if (!rsv)
            chk(cfg_o.stop_halves, 32'(sb) + 2);
         chk(cfg_o.char_bits, k == 3'h7 ? 9 : 5 + sb);
         chk(cfg_o.biphase_en, k[0]);
         chk(cfg_o.sfd_one_bit, k[1]);
         chk(cfg_o.sfd_cmd_sync, k[2]);
         chk(cfg_o.repeat_limit, k);
         chk(cfg_o.msb_first, k[0]);
         rd(OFS_MODE, m);
      end
      for (int b = 0; b < 32; b++) begin
         wr(OFS_IDIS, 32'hFFFFFFFF);
         wr(OFS_IEN, 32'h1 << b);
         rd(OFS_IMASK, (32'h1 << b) & IRQ_USED);
      end
      wr(OFS_IEN, 32'hFFFFFFFF);
      wr(OFS_IDIS, 32'h00000001);
      rd(OFS_IMASK, IRQ_USED & 32'hFFFFFFFE);
      wr(OFS_IDIS, 32'hFFFFFFFF);
      wr(OFS_IEN, 32'h00000002);
      wr(OFS_IEN, 32'h0);
      evt_flags_i <= 32'h00000001;
      cyc(3);
      chk(irq_o, 1'b0);
      evt_flags_i <= 32'h00000002;
      cyc(3);
      chk(irq_o, 1'b1);
      wr(OFS_IDIS, 32'h0);
      rd(OFS_IMASK, 32'h2);
      wr(OFS_IDIS, 32'h2);
      cyc(3);
      chk(irq_o, 1'b0);
      evt_flags_i <= 32'h0;
      m = '0;
      m.usart_mode = 4'h4;
      m.nine_bit_char = 1'b1;
      m.successive_negative_ack_limit_en = 1'b1;
      m.repeat_limit = 3'h2;
      setm();
      chr(1'b1, 1'b1);
      chr(1'b1, 1'b1);
      chr(1'b1, 1'b0);
      rd(OFS_STAT, 32'h00002400);
      wr(OFS_CTRL, 32'h00004400);
      rd(OFS_STAT, 32'h0);
      chr(1'b0, 1'b0);
      chk(rx_data_o, 9'h15A);
      m.successive_negative_ack_limit_en = 1'b0;
      setm();
      repeat (3) chr(1'b1, 1'b1);
      m.negative_ack_inhibit = 1'b1;
      setm();
      chr(1'b1, 1'b0);
      wr(OFS_TXH, 32'h000000A5);
      chk({tx_wr_o, tx_data_o}, 10'h2A5);
      m.sync_field_from_tx_write = 1'b1;
      setm();
      chk(cfg_o.sfd_cmd_sync, 1'b0);
      wr(OFS_TXH, 32'h00008000);
      cyc(1);
      chk(cfg_o.sfd_cmd_sync, 1'b1);
      m.msb_first = 1'b1;
      m.clock_out_drive = 1'b1;
      setm();
      chk({sck_oe_b_o, sck_o}, 2'b01);
      chr(1'b0, 1'b0);
      chk(rx_data_o, 9'h0B5);
      wr(OFS_TXH, 32'h000000A5);
      chk(tx_data_o, 9'h14A);
      m.clock_source_sel = CLK_EXT_SCK;
      setm();
      chk({sck_oe_b_o, sck_o}, 2'b10);
      m = '0;
      send <= 1'b1;
      for (int c = 0; c < 4; c++) begin
         m.channel_mode = 2'(c);
         tx_ser_i <= (c != 2);
         setm();
         cyc(4);
         chk(tx_seen, 1'(4'h5 >> c));
         chk(rx_ser_o, 1'(4'h8 >> c));
      end
      m.channel_mode = 2'h0;
      m.ir_filter = 1'b1;
      setm();
      send <= 1'b0;
      cyc(4);
      repeat (3) tick();
      cyc(4);
      chk(rx_ser_o, 1'b1);
      send <= 1'b1;
      cyc(4);
      tick();
      cyc(4);
      chk(rx_ser_o, 1'b1);
      tick();
      cyc(4);
      chk(rx_ser_o, 1'b0);
      test_done();
   end
endmodule : tb_usart_frame_config_irq_enable

bind ufc_core ufc_checker #(.CW(CW)) u_checker (.*);
